// [hw/pump_panel_pkg.sv]
package pump_panel_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned FAIL_RESET_MS   = 300;   // Reset press for failures
    localparam int unsigned ALARM_ACK_MS    = 2000;  // Reset press with mode button held
    localparam int unsigned MODE_TOGGLE_MS  = 3000;  // Mode button alone
    localparam int unsigned DEBOUNCE_US     = 10;
    localparam int unsigned FAIL_RESET_CYC  = FAIL_RESET_MS * (CLK_HZ / 1000);
    localparam int unsigned ALARM_ACK_CYC   = ALARM_ACK_MS * (CLK_HZ / 1000);
    localparam int unsigned MODE_TOGGLE_CYC = MODE_TOGGLE_MS * (CLK_HZ / 1000) + 1;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HOLD_W          = 32;

    // ==========================================================
    // Speed thresholds: touchdown in revolutions per second, overspeed in percent of rated
    // ==========================================================
    localparam int unsigned SPEED_W          = 16;
    localparam int unsigned TOUCHDOWN_RPS    = 75;
    localparam int unsigned OVERSPEED_HARD_PCT = 5;
    localparam int unsigned OVERSPEED_SOFT_PCT = 3;

    // ==========================================================
    // Error codes
    // ==========================================================
    localparam logic [6:0] ERR_NONE          = 7'h00;
    localparam logic [6:0] ERR_OVERSPEED_HARD = 7'h01;   // decimal 01
    localparam logic [6:0] ERR_INV_CPU       = 7'h02;
    localparam logic [6:0] ERR_SENSOR        = 7'h03;
    localparam logic [6:0] ERR_OVERSPEED_SOFT = 7'h04;
    localparam logic [6:0] ERR_BEARING       = 7'h5E;    // decimal 94
    localparam logic [6:0] FAIL_LO_MAX       = 7'h45;    // decimal 69
    localparam logic [6:0] ALARM_LO          = 7'h50;    // decimal 80
    localparam logic [6:0] ALARM_HI          = 7'h59;    // decimal 89
    localparam logic [6:0] FAIL_HI_LO        = 7'h5A;    // decimal 90
    localparam logic [6:0] FAIL_HI_HI        = 7'h63;    // decimal 99

    // ==========================================================
    // Motor states
    // ==========================================================
    typedef enum logic [1:0] {
        MOTOR_STOP    = 2'b00,
        MOTOR_RUN     = 2'b01,
        MOTOR_BRAKE   = 2'b10,
        MOTOR_FREERUN = 2'b11
    } motor_t;

    // Debounced panel buttons
    typedef struct packed {
        logic start_stop;
        logic reset;
        logic local_remote;
    } buttons_t;

    // External fault sources
    typedef struct packed {
        logic               inv_cpu_fault;
        logic               sensor_fault;
        logic               power_lost;
        logic [SPEED_W-1:0] speed_rps;
    } sense_t;

endpackage : pump_panel_pkg

// [hw/btn_debounce.sv]
`timescale 1ns/1ns
// ==========================================================
// Button debouncer: output follows input once stable
// ==========================================================
module btn_debounce
(
    // Clock and reset
    input  wire logic CORE_CLK,
    input  wire logic rst_n,
    // Button
    input  wire logic raw,
    output logic      clean
);
    logic [15:0] cnt_r;

    // Restart the count whenever input agrees with output
    always_ff @(posedge CORE_CLK)
    begin
        if (!rst_n || raw == clean)
            cnt_r <= 16'h0000;
        else
            cnt_r <= cnt_r + 16'h0001;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!rst_n)
            clean <= 1'b0;
        else if (cnt_r == 16'(pump_panel_pkg::DEBOUNCE_CYC - 1))
            clean <= raw;
    end
endmodule : btn_debounce

// [hw/hold_timer.sv]
`timescale 1ns/1ns
// ==========================================================
// Hold timer: saturating count while the gesture is held
// ==========================================================
module hold_timer
(
    // Clock and reset
    input  wire logic                              CORE_CLK,
    input  wire logic                              rst_n,
    // Gesture
    input  wire logic                              held,
    output logic [pump_panel_pkg::HOLD_W-1:0]      count
);
    // Saturate so a long hold never wraps into a fresh trigger
    always_ff @(posedge CORE_CLK)
    begin
        if (!rst_n || !held)
            count <= '0;
        else if (count != '1)
            count <= count + 1'b1;
    end
endmodule : hold_timer

// [hw/pump_fault_reset_panel.sv]
`timescale 1ns/1ns
// Summary of operation
// - Reset held 0.3 s clears failure messages
// - Panel reset and acknowledge only when local
// - Mode button alone over 3 s toggles
// - Mode plus reset 2 s acknowledges alarms
// - Brake is kept after failure reset
// - Freerun is kept after failure reset
// - Rotation resumes only on fresh start
// - Freerun: first press brakes, second accelerates
// - Codes 01-69, 90-99 are failures
// - Codes 80-89 are alarms
// - Alarms never stop the pump
// - Persisting cause re-raises or blocks reset
// - Hard overspeed +5% freerun, not resettable
// - Soft overspeed +3% freerun, resettable
// - Inverter processor fault freerun, no reset
// - Sensor circuit fault freerun, no reset
// - Power-loss touchdown in freerun locks out
// - Lockout only at 75 rps or more
module pump_fault_reset_panel
(
    // Clock and reset
    input  wire logic                                   CORE_CLK,
    input  wire logic                                   RST_N,
    // Front panel buttons, high while pressed
    input  wire logic                                   BTN_START_STOP,
    input  wire logic                                   BTN_RESET,
    input  wire logic                                   BTN_LOCAL_REMOTE,
    // Remote command source, one-cycle pulses
    input  wire logic                                   REM_START,
    input  wire logic                                   REM_STOP,
    input  wire logic                                   REM_FAIL_RESET,
    // Protection sensing
    input  wire logic                                   INV_CPU_FAULT,
    input  wire logic                                   SENSOR_FAULT,
    input  wire logic                                   POWER_LOST,
    input  wire logic [pump_panel_pkg::SPEED_W-1:0]     SPEED_RPS,
    input  wire logic [pump_panel_pkg::SPEED_W-1:0]     RATED_RPS,
    // Other subsystem reports, code 0 when none
    input  wire logic [6:0]                             EXT_ERR_CODE,
    input  wire logic                                   EXT_ERR_VALID,
    input  wire logic                                   EXT_ERR_BRAKE,
    input  wire logic                                   EXT_ERR_RESETTABLE,
    // Status
    output logic                                        REMOTE_MODE,
    output logic [6:0]                                  FAIL_CODE,
    output logic                                        FAIL_ACTIVE,
    output logic [6:0]                                  ALARM_CODE,
    output logic                                        ALARM_ACTIVE,
    output logic [1:0]                                  MOTOR_STATE,
    output logic                                        BEARING_LOCKOUT
);

    // ==========================================================
    // Debounce and hold timing
    // ==========================================================
    // Raw and clean buttons, sensing, hold counts
    pump_panel_pkg::buttons_t raw_btn, btn;
    pump_panel_pkg::sense_t   sense;
    logic [pump_panel_pkg::HOLD_W-1:0] rst_cnt, ack_cnt, mode_cnt;

    assign raw_btn = '{start_stop: BTN_START_STOP, reset: BTN_RESET, local_remote: BTN_LOCAL_REMOTE};
    assign sense   = '{inv_cpu_fault: INV_CPU_FAULT, sensor_fault: SENSOR_FAULT,
                       power_lost: POWER_LOST, speed_rps: SPEED_RPS};

    // One debouncer per button
    btn_debounce u_db_ss
    (
        .CORE_CLK(CORE_CLK),
        .rst_n(RST_N),
        .raw(raw_btn.start_stop),
        .clean(btn.start_stop)
    );
    btn_debounce u_db_rs
    (
        .CORE_CLK(CORE_CLK),
        .rst_n(RST_N),
        .raw(raw_btn.reset),
        .clean(btn.reset)
    );
    btn_debounce u_db_lr
    (
        .CORE_CLK(CORE_CLK),
        .rst_n(RST_N),
        .raw(raw_btn.local_remote),
        .clean(btn.local_remote)
    );

    // Gestures: reset alone, reset with mode, mode alone
    wire g_reset_only = btn.reset && !btn.local_remote;
    wire g_ack        = btn.reset && btn.local_remote;
    wire g_mode_only  = btn.local_remote && !btn.reset;

    hold_timer u_ht_rs
    (
        .CORE_CLK(CORE_CLK),
        .rst_n(RST_N),
        .held(g_reset_only),
        .count(rst_cnt)
    );
    hold_timer u_ht_ak
    (
        .CORE_CLK(CORE_CLK),
        .rst_n(RST_N),
        .held(g_ack),
        .count(ack_cnt)
    );
    hold_timer u_ht_md
    (
        .CORE_CLK(CORE_CLK),
        .rst_n(RST_N),
        .held(g_mode_only),
        .count(mode_cnt)
    );

    // ==========================================================
    // Gesture decode
    // ==========================================================
    logic ack_used_r;      // Mode press that took part in an acknowledge
    logic ss_prev_r;

    // fires once as the hold reaches 0.3 s
    wire reset_hit  = (rst_cnt == 32'(pump_panel_pkg::FAIL_RESET_CYC));
    // reset held 2 s with mode button down
    wire ack_hit    = (ack_cnt == 32'(pump_panel_pkg::ALARM_ACK_CYC));
    // strictly longer than 3 s; a press that joined an acknowledge is spent
    wire mode_hit   = (mode_cnt == 32'(pump_panel_pkg::MODE_TOGGLE_CYC)) && !ack_used_r;
    // Start/stop acts on the clean rising edge
    wire ss_press   = btn.start_stop && !ss_prev_r;

    // panel reset and acknowledge need local mode
    wire local_mode   = !REMOTE_MODE;
    wire do_fail_rst  = (reset_hit && local_mode) || (REM_FAIL_RESET && REMOTE_MODE);
    wire do_alarm_ack = ack_hit && local_mode;
    wire start_cmd    = (ss_press && local_mode) || (REM_START && REMOTE_MODE);
    wire stop_cmd     = (ss_press && local_mode) || (REM_STOP && REMOTE_MODE);

    // Edge history and spent mode press
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            ss_prev_r  <= 1'b0;
            ack_used_r <= 1'b0;
        end
        else
        begin
            ss_prev_r  <= btn.start_stop;
            // combination never counts as a mode change
            ack_used_r <= btn.local_remote && (ack_used_r || btn.reset);
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            REMOTE_MODE <= 1'b0;
        else if (mode_hit)
            REMOTE_MODE <= !REMOTE_MODE;
    end

    // ==========================================================
    // Fault detection
    // ==========================================================
    // Scaled by 100 so no divider is needed
    logic [pump_panel_pkg::SPEED_W+7:0] spd_x100, hard_lim, soft_lim;
    assign spd_x100 = {8'h00, SPEED_RPS} * 24'(100);
    assign hard_lim = {8'h00, RATED_RPS} * 24'(100 + pump_panel_pkg::OVERSPEED_HARD_PCT);
    assign soft_lim = {8'h00, RATED_RPS} * 24'(100 + pump_panel_pkg::OVERSPEED_SOFT_PCT);

    wire hard_os  = spd_x100 > hard_lim;
    wire soft_os  = spd_x100 > soft_lim;
    // touchdown on power loss while freerunning
    // only at 75 rps or more
    wire touchdown = sense.power_lost && (MOTOR_STATE == pump_panel_pkg::MOTOR_FREERUN)
                     && (sense.speed_rps >= 16'(pump_panel_pkg::TOUCHDOWN_RPS));

    wire ext_fail  = EXT_ERR_VALID &&
                     ((EXT_ERR_CODE != pump_panel_pkg::ERR_NONE && EXT_ERR_CODE <= pump_panel_pkg::FAIL_LO_MAX)
                      || (EXT_ERR_CODE >= pump_panel_pkg::FAIL_HI_LO && EXT_ERR_CODE <= pump_panel_pkg::FAIL_HI_HI));
    wire ext_alarm = EXT_ERR_VALID && EXT_ERR_CODE >= pump_panel_pkg::ALARM_LO
                     && EXT_ERR_CODE <= pump_panel_pkg::ALARM_HI;

    // Highest priority first; internal sources beat external codes
    logic [6:0] new_code;
    logic       new_fail, new_brake, new_clearable;
    always_comb
    begin
        new_fail      = 1'b1;
        new_brake     = 1'b0;
        new_clearable = 1'b0;
        new_code      = pump_panel_pkg::ERR_NONE;
        if (touchdown || BEARING_LOCKOUT)
            new_code = pump_panel_pkg::ERR_BEARING;
        else if (sense.inv_cpu_fault)
            new_code = pump_panel_pkg::ERR_INV_CPU;
        else if (sense.sensor_fault)
            new_code = pump_panel_pkg::ERR_SENSOR;
        else if (hard_os)
            new_code = pump_panel_pkg::ERR_OVERSPEED_HARD;
        else if (soft_os)
        begin
            new_code      = pump_panel_pkg::ERR_OVERSPEED_SOFT;
            new_clearable = 1'b1;
        end
        else if (ext_fail)
        begin
            new_code      = EXT_ERR_CODE;
            new_brake     = EXT_ERR_BRAKE;
            new_clearable = EXT_ERR_RESETTABLE;
        end
        else
            new_fail = 1'b0;
    end

    // ==========================================================
    // Failure latch
    // ==========================================================
    // May the latched failure be cleared
    logic fail_clearable_r;

    // a live cause refuses the clear and re-raises
    wire clear_ok = do_fail_rst && fail_clearable_r && !new_fail;

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            FAIL_ACTIVE      <= 1'b0;
            FAIL_CODE        <= pump_panel_pkg::ERR_NONE;
            fail_clearable_r <= 1'b0;
        end
        // New failure wins over a clear in the same cycle
        else if (new_fail && (!FAIL_ACTIVE || new_code != FAIL_CODE))
        begin
            FAIL_ACTIVE      <= 1'b1;
            FAIL_CODE        <= new_code;
            fail_clearable_r <= new_clearable;
        end
        else if (clear_ok)
        begin
            FAIL_ACTIVE <= 1'b0;
            FAIL_CODE   <= pump_panel_pkg::ERR_NONE;
        end
    end

    // lockout survives everything but power-on reset
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            BEARING_LOCKOUT <= 1'b0;
        else if (touchdown)
            BEARING_LOCKOUT <= 1'b1;
    end

    // ==========================================================
    // Alarm latch
    // ==========================================================
    // Alarms only report; the motor never sees them
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            ALARM_ACTIVE <= 1'b0;
            ALARM_CODE   <= pump_panel_pkg::ERR_NONE;
        end
        // Set wins over acknowledge
        else if (ext_alarm)
        begin
            ALARM_ACTIVE <= 1'b1;
            ALARM_CODE   <= EXT_ERR_CODE;
        end
        else if (do_alarm_ack)
        begin
            ALARM_ACTIVE <= 1'b0;
            ALARM_CODE   <= pump_panel_pkg::ERR_NONE;
        end
    end

    // ==========================================================
    // Motor state
    // ==========================================================
    // Rotor control state
    pump_panel_pkg::motor_t motor_r, motor_nxt;

    // alarms take no part in motor control
    always_comb
    begin
        motor_nxt = motor_r;
        if (new_fail)
            motor_nxt = new_brake ? pump_panel_pkg::MOTOR_BRAKE : pump_panel_pkg::MOTOR_FREERUN;
        else if (!FAIL_ACTIVE && !BEARING_LOCKOUT)
        begin
            case (motor_r)
                pump_panel_pkg::MOTOR_STOP:
                    if (start_cmd)
                        motor_nxt = pump_panel_pkg::MOTOR_RUN;
                pump_panel_pkg::MOTOR_RUN:
                    if (stop_cmd)
                        motor_nxt = pump_panel_pkg::MOTOR_BRAKE;
                // brake held until a fresh start
                // restart needs a new start command
                pump_panel_pkg::MOTOR_BRAKE:
                    if (start_cmd)
                        motor_nxt = pump_panel_pkg::MOTOR_RUN;
                // first press brakes, remote start runs
                pump_panel_pkg::MOTOR_FREERUN:
                    if (ss_press && local_mode)
                        motor_nxt = pump_panel_pkg::MOTOR_BRAKE;
                    else if (REM_START && REMOTE_MODE)
                        motor_nxt = pump_panel_pkg::MOTOR_RUN;
                default:
                    motor_nxt = pump_panel_pkg::MOTOR_STOP;
            endcase
        end
    end

    // State register
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            motor_r <= pump_panel_pkg::MOTOR_STOP;
        else
            motor_r <= motor_nxt;
    end

    // Output straight from the state flop
    assign MOTOR_STATE = motor_r;

endmodule : pump_fault_reset_panel

// [verif/pump_panel_monitor.sv]
`timescale 1ns/1ns
// ==========================================================
// Protection checker on the top-level ports
// ==========================================================
module pump_panel_monitor
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Protection sensing
    input  wire logic        INV_CPU_FAULT,
    input  wire logic        SENSOR_FAULT,
    input  wire logic        POWER_LOST,
    input  wire logic [15:0] SPEED_RPS,
    input  wire logic [15:0] RATED_RPS,
    input  wire logic [6:0]  EXT_ERR_CODE,
    input  wire logic        EXT_ERR_VALID,
    // Status
    input  wire logic [6:0]  FAIL_CODE,
    input  wire logic        FAIL_ACTIVE,
    input  wire logic [6:0]  ALARM_CODE,
    input  wire logic        ALARM_ACTIVE,
    input  wire logic [1:0]  MOTOR_STATE,
    input  wire logic        BEARING_LOCKOUT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // ==========================================================
    // Building blocks
    // ==========================================================
    // Power dropped while the rotor coasts fast
    sequence s_touch;
        POWER_LOST && MOTOR_STATE == 2'h3 && SPEED_RPS >= 16'h004B;
    endsequence
    // Maintenance code reported alone
    sequence s_alarm;
        EXT_ERR_VALID && EXT_ERR_CODE >= 7'h50 && EXT_ERR_CODE <= 7'h59 && !FAIL_ACTIVE
        && !INV_CPU_FAULT && !SENSOR_FAULT && !POWER_LOST && SPEED_RPS <= RATED_RPS;
    endsequence

    // ==========================================================
    // Assertions
    // ==========================================================
    a_cpu_fault_freerun: assert property (INV_CPU_FAULT && !EXT_ERR_VALID && !FAIL_ACTIVE
        |=> FAIL_ACTIVE && MOTOR_STATE == 2'h3) else $error("cpu fault did not freerun");
    a_sensor_fault_freerun: assert property (SENSOR_FAULT && !EXT_ERR_VALID && !FAIL_ACTIVE
        |=> FAIL_ACTIVE && MOTOR_STATE == 2'h3) else $error("sensor fault did not freerun");
    a_overspeed_trip: assert property (!EXT_ERR_VALID && !FAIL_ACTIVE
        && 32'(SPEED_RPS) * 32'h64 > 32'(RATED_RPS) * 32'h67
        |=> FAIL_ACTIVE && MOTOR_STATE == 2'h3) else $error("overspeed did not trip");
    a_alarm_no_stop: assert property (s_alarm
        |=> ALARM_ACTIVE && !FAIL_ACTIVE && ALARM_CODE == $past(EXT_ERR_CODE)) else $error("alarm misfiled");
    a_failure_range: assert property (EXT_ERR_VALID && ((EXT_ERR_CODE >= 7'h01 && EXT_ERR_CODE <= 7'h45)
        || (EXT_ERR_CODE >= 7'h5A && EXT_ERR_CODE <= 7'h63)) |=> FAIL_ACTIVE) else $error("failure not raised");
    a_no_run_failed: assert property (FAIL_ACTIVE |-> MOTOR_STATE != 2'h1) else $error("runs in failure");
    a_lockout_sticky: assert property (BEARING_LOCKOUT
        |=> BEARING_LOCKOUT && MOTOR_STATE != 2'h1) else $error("lockout lost");
    a_slow_no_lock: assert property (POWER_LOST && SPEED_RPS < 16'h004B && !BEARING_LOCKOUT
        |=> !BEARING_LOCKOUT) else $error("lockout below threshold");
    a_touchdown_lock: assert property (s_touch
        |=> BEARING_LOCKOUT && FAIL_CODE == 7'h5E) else $error("touchdown not locked");
endmodule : pump_panel_monitor

// [verif/panel_operator.sv]
`timescale 1ns/1ns
// ==========================================================
// Operator at the front panel
// ==========================================================
module panel_operator
(
    // Clock
    input  wire logic                 CORE_CLK,
    // Buttons, high while pressed
    output pump_panel_pkg::buttons_t  btn
);
    initial
    begin
        btn = 3'h0;
    end

    // timed hold, then all buttons let go
    task automatic press(input pump_panel_pkg::buttons_t which, input int unsigned cycles);
        @(posedge CORE_CLK);
        btn <= which;
        repeat (cycles) @(posedge CORE_CLK);
        btn <= 3'h0;
    endtask : press
endmodule : panel_operator

// [verif/pump_fault_reset_panel_test.sv]
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench
// ==========================================================
module pump_fault_reset_panel_test;
    localparam pump_panel_pkg::buttons_t B_START = 3'h4;
    localparam pump_panel_pkg::buttons_t B_RESET = 3'h2;
    localparam pump_panel_pkg::buttons_t B_MODE  = 3'h1;
    logic                      core_clk = 1'b0;
    logic                      rst_n    = 1'b0;
    pump_panel_pkg::buttons_t  btn;
    logic                      cpu_f    = 1'b0;
    logic                      sens_f   = 1'b0;
    logic                      pwr_l    = 1'b0;
    logic [15:0]               spd      = 16'h0000;
    logic [6:0]                ext_code = 7'h00;
    logic                      ext_v    = 1'b0;
    logic                      ext_b    = 1'b0;
    logic                      rmode;
    logic [6:0]                fcode;
    logic                      fact;
    logic [6:0]                acode;
    logic                      aact;
    logic [1:0]                mstate;
    logic                      lock;
    int                        err_count    = 0;
    int                        total_checks = 0;

    // Clock runs at 100 MHz
    always #5 core_clk = ~core_clk;

    panel_operator u_panel_operator (.CORE_CLK(core_clk), .btn(btn));
    pump_fault_reset_panel u_pump_fault_reset_panel
    (
        .CORE_CLK(core_clk), .RST_N(rst_n),
        .BTN_START_STOP(btn.start_stop), .BTN_RESET(btn.reset), .BTN_LOCAL_REMOTE(btn.local_remote),
        .REM_START(1'b0), .REM_STOP(1'b0), .REM_FAIL_RESET(1'b0),
        .INV_CPU_FAULT(cpu_f), .SENSOR_FAULT(sens_f), .POWER_LOST(pwr_l),
        .SPEED_RPS(spd), .RATED_RPS(16'h03E8),
        .EXT_ERR_CODE(ext_code), .EXT_ERR_VALID(ext_v), .EXT_ERR_BRAKE(ext_b), .EXT_ERR_RESETTABLE(1'b1),
        .REMOTE_MODE(rmode), .FAIL_CODE(fcode), .FAIL_ACTIVE(fact), .ALARM_CODE(acode),
        .ALARM_ACTIVE(aact), .MOTOR_STATE(mstate), .BEARING_LOCKOUT(lock)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Sample a little after the edge so that its updates have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    // Gap after release lets the debounced level fall before the next press
    task automatic press(input pump_panel_pkg::buttons_t which, input int unsigned n);
        u_panel_operator.press(which, n);
        wait_cyc(1100);
    endtask : press

    // Sources cleared while reset is held for 12 cycles
    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        ext_v <= 1'b0;
        cpu_f <= 1'b0;
        sens_f <= 1'b0;
        pwr_l <= 1'b0;
        spd <= 16'h0000;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask : do_reset

    // ==========================================================
    // Scenarios
    // ==========================================================
    // local start and stop sequence
    task automatic t_start_stop();
        press(B_START, 1100);
        check("motor", 16'(mstate), 16'h0001);
        press(B_START, 1100);
        check("motor", 16'(mstate), 16'h0002);
        press(B_START, 1100);
        check("motor", 16'(mstate), 16'h0001);
    endtask : t_start_stop

    // Alarm keeps the pump turning; short gestures do nothing
    task automatic t_alarm_run();
        @(posedge core_clk);
        ext_code <= 7'h52;
        ext_v <= 1'b1;
        repeat (3) @(posedge core_clk);
        ext_v <= 1'b0;
        #1;
        check("alarm", 16'(aact), 16'h0001);
        check("alarm code", 16'(acode), 16'h0052);
        check("motor", 16'(mstate), 16'h0001);
        check("fail", 16'(fact), 16'h0000);
        press(B_RESET | B_MODE, 3000);
        check("alarm", 16'(aact), 16'h0001);
        press(B_MODE, 3000);
        check("mode", 16'(rmode), 16'h0000);
        check("motor", 16'(mstate), 16'h0001);
    endtask : t_alarm_run

    // Braking failure holds the brake against start and short reset
    task automatic t_brake_fail();
        @(posedge core_clk);
        ext_code <= 7'h45;
        ext_b <= 1'b1;
        ext_v <= 1'b1;
        repeat (3) @(posedge core_clk);
        ext_v <= 1'b0;
        #1;
        check("fail code", 16'(fcode), 16'h0045);
        check("motor", 16'(mstate), 16'h0002);
        press(B_START, 1100);
        check("motor", 16'(mstate), 16'h0002);
        press(B_RESET, 3000);
        check("fail", 16'(fact), 16'h0001);
    endtask : t_brake_fail

    // Range edges of failure and alarm codes
    task automatic t_classify();
        logic [6:0] codes [6];
        codes = '{7'h01, 7'h45, 7'h5A, 7'h63, 7'h50, 7'h59};
        foreach (codes[i])
        begin
            do_reset();
            ext_code <= codes[i];
            ext_b <= 1'b0;
            ext_v <= 1'b1;
            wait_cyc(3);
            check("fail", 16'(fact), 16'(i < 4));
            check("alarm", 16'(aact), 16'(i >= 4));
        end
    endtask : t_classify

    // Internal causes, touchdown, then the 3 percent edge
    task automatic t_internal();
        logic [6:0] exp [4];
        exp = '{7'h02, 7'h03, 7'h04, 7'h01};
        for (int k = 0; k < 4; k++)
        begin
            do_reset();
            cpu_f <= (k == 0);
            sens_f <= (k == 1);
            spd <= (k == 2) ? 16'h0410 : ((k == 3) ? 16'h0424 : 16'h0000);
            wait_cyc(2);
            check("motor", 16'(mstate), 16'h0003);
            check("fail code", 16'(fcode), 16'(exp[k]));
        end
        @(posedge core_clk);
        spd <= 16'h004A;
        pwr_l <= 1'b1;
        wait_cyc(3);
        check("lockout", 16'(lock), 16'h0000);
        @(posedge core_clk);
        spd <= 16'h004B;
        wait_cyc(3);
        check("lockout", 16'(lock), 16'h0001);
        check("fail code", 16'(fcode), 16'h005E);
        @(posedge core_clk);
        pwr_l <= 1'b0;
        press(B_START, 1100);
        check("motor", 16'(mstate), 16'h0003);
        do_reset();
        spd <= 16'h0406;
        wait_cyc(3);
        check("fail", 16'(fact), 16'h0000);
    endtask : t_internal

    // ==========================================================
    // Sequence, watchdog and verdict
    // ==========================================================
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial
    begin
        do_reset();
        t_start_stop();
        t_alarm_run();
        t_brake_fail();
        t_classify();
        t_internal();
        tally_and_finish();
    end

    // About two and a half times the expected run length
    initial
    begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
endmodule : pump_fault_reset_panel_test

bind pump_fault_reset_panel pump_panel_monitor u_pump_panel_monitor (.*);
